/* File: hpl_pkg.sv */
// Shared constants and types for the host parallel link
package hpl_pkg;
  // ==========================================================
  // Widths
  localparam int DATA_W       = 8;    // Link data bus width
  localparam int ADDR_W       = 3;    // Board address select width
  localparam int SUPPLY_W     = 3;    // Host supply sense lines
  // ==========================================================
  // Reset values
  localparam logic [7:0] DATA_RST = 8'h00; // Data register reset
  localparam logic [2:0] ADDR_RST = 3'h0;  // Default slave address
  // Synchroniser depth
  localparam int SYNC_STAGES  = 2;    // Flops per async input
  // Buffer depth
  localparam int BUF_DEPTH    = 2;    // Two-entry skid buffer

  // Link handshake states
  typedef enum logic [1:0] {
    HPL_IDLE,
    HPL_WAIT_ACK,
    HPL_WAIT_REL
  } hpl_state_t;

  // Reset kinds requested by the host
  typedef enum logic [1:0] {
    HPL_RST_NONE,
    HPL_RST_HARD,
    HPL_RST_SOFT
  } hpl_rst_kind_t;
endpackage : hpl_pkg

/* File: hpl_link_if.sv */
// Parallel link wires between host adapter and board
interface hpl_link_if;
  logic [2:0] board_addr_select;     // Host address select
  logic       broadcast_select;      // Host broadcast
  logic       host_present_n;        // Held low by attached host
  logic       host_break_request;    // Host break
  logic       host_reset_request;    // Host reset
  logic       host_req;              // Host to board request
  logic       board_ack_to_host;     // Board acknowledge
  logic       board_to_host_req;     // Board to host request
  logic       host_ack_to_board;     // Host acknowledge
  logic       host_int_ack;          // Host interrupt acknowledge
  logic       irq_source_flag;       // Per-board interrupt source
  logic       shared_host_irq_o;     // Board pull on shared irq
  logic       shared_host_irq_oe_n;  // Low while board pulls
  logic       shared_host_irq_n;     // Resolved wired level
  logic [2:0] host_supply;           // Host supply sense
  logic [7:0] board_data_o;          // Board data out
  logic       board_data_oe_n;       // Low while board drives
  logic [7:0] host_data_o;           // Host data out
  logic       host_data_oe_n;        // Low while host drives
  logic [7:0] link_data_bus;         // Resolved bus value

  // Wired-AND of the open-collector line, pull-up idle high
  assign shared_host_irq_n = shared_host_irq_oe_n ? 1'b1
                                                  : shared_host_irq_o;
  // Bus resolution, board wins a (forbidden) clash
  assign link_data_bus = !board_data_oe_n ? board_data_o
                       : (!host_data_oe_n ? host_data_o : 8'hff);

  modport board (
    input  board_addr_select, broadcast_select, host_present_n,
    input  host_break_request, host_reset_request, host_req,
    input  host_ack_to_board, host_int_ack, host_supply,
    input  link_data_bus,
    output board_ack_to_host, board_to_host_req, irq_source_flag,
    output shared_host_irq_o, shared_host_irq_oe_n,
    output board_data_o, board_data_oe_n
  );

  modport host (
    output board_addr_select, broadcast_select, host_present_n,
    output host_break_request, host_reset_request, host_req,
    output host_ack_to_board, host_int_ack, host_supply,
    output host_data_o, host_data_oe_n,
    input  board_ack_to_host, board_to_host_req, irq_source_flag,
    input  shared_host_irq_n, link_data_bus
  );
endinterface : hpl_link_if

/* File: hpl_board.sv */
// Board end of the host parallel link
module hpl_board #(
  parameter logic [2:0] SLAVE_ADDR = hpl_pkg::ADDR_RST // Board address
) (
  input  wire logic                     sys_clk,       // Board clock
  input  wire logic                     reset,         // Sync, high
  hpl_link_if.board                     link,          // Host link
  // Board-to-host word stream
  input  wire logic [hpl_pkg::DATA_W-1:0] tx_data,     // Word to send
  input  wire logic                     tx_valid,      // Word offered
  output logic                          tx_ready,      // Word taken
  // Host-to-board word stream
  output logic [hpl_pkg::DATA_W-1:0]    rx_data,       // Received word
  output logic                          rx_valid,      // Word present
  input  wire logic                     rx_ready,      // Consumer takes
  // Board processor side
  input  wire logic                     irq_raise,     // Interrupt host
  output logic                          nmi_level7,    // Level 7 request
  output logic                          hard_reset_req,// Hard reset
  output logic                          soft_reset_req,// Soft reset
  output logic                          host_attached, // Host present
  output logic [hpl_pkg::SUPPLY_W-1:0]  host_powered,  // Supply sense
  output logic                          transceiver_gate_n // Gate
);
  import hpl_pkg::*;

  // ==========================================================
  // Input synchronisers
  localparam int NS = 3 + 1 + 1 + 1 + 1 + 1 + 1 + 1 + SUPPLY_W;
  logic [NS-1:0] raw;                 // Raw host inputs
  logic [NS-1:0] s1_q;                // First stage
  logic [NS-1:0] s2_q;                // Second stage, used
  assign raw = {link.board_addr_select, link.broadcast_select,
                link.host_present_n, link.host_break_request,
                link.host_reset_request, link.host_req,
                link.host_ack_to_board, link.host_int_ack,
                link.host_supply};

  // Two flop stages per input
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  logic [2:0] sel;                    // Synced address select
  logic       bcast, pres_n, brk, rst_rq, hreq, hack, iack;
  logic [SUPPLY_W-1:0] sup;           // Synced supply sense
  assign {sel, bcast, pres_n, brk, rst_rq, hreq, hack, iack, sup} = s2_q;

  // Address or broadcast match
  function automatic logic match_f(input logic [2:0] a, input logic b);
    return (a == SLAVE_ADDR) || b;
  endfunction

  logic hit;                          // Board addressed
  logic attached;                     // Host present
  assign hit      = match_f(sel, bcast);
  assign attached = !pres_n;

  // ==========================================================
  // Status outputs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      host_attached <= 1'b0;
      host_powered  <= '0;
    end else begin
      host_attached <= attached;
      host_powered  <= sup;
    end
  end

  // ==========================================================
  // Break and reset requests
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nmi_level7     <= 1'b0;
      hard_reset_req <= 1'b0;
      soft_reset_req <= 1'b0;
    end else begin
      nmi_level7     <= attached && brk && hit;
      // Interrupt ack high picks hard reset
      hard_reset_req <= attached && rst_rq && hit && iack;
      soft_reset_req <= attached && rst_rq && hit && !iack;
    end
  end

  // ==========================================================
  // Host interrupt: source flag and shared line
  logic irq_q;                        // Pending interrupt
  always_ff @(posedge sys_clk) begin
    if (reset)
      irq_q <= 1'b0;
    else if (irq_raise)
      irq_q <= 1'b1;                  // Set wins over ack
    else if (iack && !rst_rq)
      irq_q <= 1'b0;
  end
  assign link.irq_source_flag      = irq_q;
  assign link.shared_host_irq_o    = 1'b0;
  assign link.shared_host_irq_oe_n = !irq_q;

  // ==========================================================
  // Two-entry receive buffer
  logic [DATA_W-1:0] rbuf_q [BUF_DEPTH]; // Storage
  logic [1:0] rcnt_q;                 // Fill level
  logic       rrd_q, rwr_q;           // Read / write index
  logic       rpush, rpop;            // Buffer strobes
  assign rx_valid = rcnt_q != 2'h0;
  assign rx_data  = rbuf_q[rrd_q];
  assign rpop     = rx_valid && rx_ready;

  // Buffer storage and pointers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rcnt_q <= 2'h0;
      rrd_q  <= 1'b0;
      rwr_q  <= 1'b0;
      rbuf_q[0] <= DATA_RST;
      rbuf_q[1] <= DATA_RST;
    end else begin
      if (rpush) begin
        rbuf_q[rwr_q] <= link.link_data_bus;
        rwr_q <= !rwr_q;
      end
      if (rpop)
        rrd_q <= !rrd_q;
      rcnt_q <= rcnt_q + {1'b0, rpush} - {1'b0, rpop};
    end
  end

  // ==========================================================
  // Receive handshake
  hpl_state_t rst_q;                  // Receive state
  hpl_state_t tst_q;                  // Transmit state, read here too
  logic       rdir;                   // Receive owns the bus
  always_ff @(posedge sys_clk) begin
    if (reset)
      rst_q <= HPL_IDLE;
    else
      case (rst_q)
        // Take a word only when addressed and room exists
        HPL_IDLE:
          if (hreq && hit && rcnt_q != 2'(BUF_DEPTH) && tst_q == HPL_IDLE)
            rst_q <= HPL_WAIT_REL;
        HPL_WAIT_REL:
          if (!hreq)
            rst_q <= HPL_IDLE;
        default: rst_q <= HPL_IDLE;
      endcase
  end
  assign rpush = rst_q == HPL_IDLE && hreq && hit
               && rcnt_q != 2'(BUF_DEPTH) && tst_q == HPL_IDLE;
  assign link.board_ack_to_host = rst_q == HPL_WAIT_REL;
  assign rdir = rst_q != HPL_IDLE;

  // ==========================================================
  // Transmit handshake
  logic [DATA_W-1:0] tdat_q;          // Word on the bus
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tst_q  <= HPL_IDLE;
      tdat_q <= DATA_RST;
    end else
      case (tst_q)
        // Load data a cycle ahead of the request
        HPL_IDLE:
          if (tx_valid && !rdir && !hreq) begin
            tdat_q <= tx_data;
            tst_q  <= HPL_WAIT_ACK;
          end
        HPL_WAIT_ACK:
          if (hack)
            tst_q <= HPL_WAIT_REL;
        HPL_WAIT_REL:
          if (!hack)
            tst_q <= HPL_IDLE;
        default: tst_q <= HPL_IDLE;
      endcase
  end
  assign tx_ready = tst_q == HPL_IDLE && !rdir && !hreq;

  // Request one cycle after the data settles
  logic treq_q;                       // Board request flop
  always_ff @(posedge sys_clk) begin
    if (reset)
      treq_q <= 1'b0;
    else
      treq_q <= tst_q == HPL_WAIT_ACK && !hack;
  end
  assign link.board_to_host_req = treq_q;

  // ==========================================================
  // Bus direction and transceiver gate
  assign link.board_data_o    = tdat_q;
  assign link.board_data_oe_n = tst_q == HPL_IDLE;
  always_ff @(posedge sys_clk) begin
    if (reset)
      transceiver_gate_n <= 1'b1;
    else
      transceiver_gate_n <= !(attached && hit);
  end
endmodule : hpl_board

/* File: hpl_host.sv */
// Host adapter end of the host parallel link
module hpl_host (
  input  wire logic                     sys_clk,       // Host clock
  input  wire logic                     reset,         // Sync, high
  hpl_link_if.host                      link,          // Board link
  // Control levels
  input  wire logic [2:0]               target_addr,   // Board select
  input  wire logic                     broadcast,     // All boards
  input  wire logic                     do_break,      // Break level
  input  wire logic                     do_reset,      // Reset level
  input  wire logic                     hard_kind,     // Hard reset
  input  wire logic                     int_ack,       // Interrupt ack
  input  wire logic [2:0]               supply_on,     // Supply lines
  // Host-to-board word stream
  input  wire logic [hpl_pkg::DATA_W-1:0] tx_data,     // Word to send
  input  wire logic                     tx_valid,      // Word offered
  output logic                          tx_ready,      // Word taken
  // Board-to-host word stream
  output logic [hpl_pkg::DATA_W-1:0]    rx_data,       // Received word
  output logic                          rx_valid,      // Word pulse
  output logic                          irq_pending,   // Shared irq low
  output logic                          irq_source     // Board flag
);
  import hpl_pkg::*;

  // ==========================================================
  // Static lines
  assign link.board_addr_select  = target_addr;
  assign link.broadcast_select   = broadcast;
  assign link.host_present_n     = 1'b0;
  assign link.host_break_request = do_break;
  assign link.host_reset_request = do_reset;
  // Ack line doubles as reset kind
  assign link.host_int_ack = do_reset ? hard_kind : int_ack;
  assign link.host_supply  = supply_on;
  assign irq_pending = !link.shared_host_irq_n;
  assign irq_source  = link.irq_source_flag;

  // ==========================================================
  // Host-to-board write
  hpl_state_t wst_q;                  // Write state
  logic [DATA_W-1:0] wdat_q;          // Word on the bus
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wst_q  <= HPL_IDLE;
      wdat_q <= DATA_RST;
    end else
      case (wst_q)
        HPL_IDLE:
          if (tx_valid && !link.board_to_host_req) begin
            wdat_q <= tx_data;
            wst_q  <= HPL_WAIT_ACK;
          end
        HPL_WAIT_ACK:
          if (link.board_ack_to_host)
            wst_q <= HPL_WAIT_REL;
        HPL_WAIT_REL:
          if (!link.board_ack_to_host)
            wst_q <= HPL_IDLE;
        default: wst_q <= HPL_IDLE;
      endcase
  end
  assign tx_ready = wst_q == HPL_IDLE && !link.board_to_host_req;
  assign link.host_req       = wst_q == HPL_WAIT_ACK;
  assign link.host_data_o    = wdat_q;
  // Let go of the bus once acked, so a board write cannot clash
  assign link.host_data_oe_n = wst_q != HPL_WAIT_ACK;

  // ==========================================================
  // Board-to-host read
  logic ack_q;                        // Host acknowledge
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_q    <= 1'b0;
      rx_valid <= 1'b0;
      rx_data  <= DATA_RST;
    end else begin
      rx_valid <= link.board_to_host_req && !ack_q;
      if (link.board_to_host_req && !ack_q)
        rx_data <= link.link_data_bus;
      ack_q <= link.board_to_host_req;
    end
  end
  assign link.host_ack_to_board = ack_q;
endmodule : hpl_host

/* File: hpl_link_sva.sv */
// Checker for the host parallel link handshakes, bus and shared interrupt
module hpl_link_sva #(
  parameter logic [2:0] SLAVE_ADDR = 3'h0 // Board address under test
) (
  input wire logic       sys_clk,              // Board clock
  input wire logic       reset,                // Sync, active high
  input wire logic [2:0] board_addr_select,    // Host address select
  input wire logic       broadcast_select,     // Host broadcast
  input wire logic       host_present_n,       // Low while host attached
  input wire logic       host_reset_request,   // Host reset
  input wire logic       host_req,             // Host to board request
  input wire logic       board_ack_to_host,    // Board acknowledge
  input wire logic       board_to_host_req,    // Board to host request
  input wire logic       host_ack_to_board,    // Host acknowledge
  input wire logic       host_int_ack,         // Interrupt acknowledge
  input wire logic       irq_source_flag,      // Per-board source flag
  input wire logic       shared_host_irq_o,    // Board pull value
  input wire logic       shared_host_irq_oe_n, // Low while board pulls
  input wire logic       shared_host_irq_n,    // Resolved wired level
  input wire logic       board_data_oe_n,      // Low while board drives
  input wire logic       host_data_oe_n        // Low while host drives
);
  // ==========================================================
  // Shared clocking and reset
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // ==========================================================
  // Named steps of the handshakes
  sequence host_req_dropped;  // Ack seen, host has let go
    board_ack_to_host && !host_req;
  endsequence
  sequence int_ack_held;      // Ack stable long enough to pass sync
    (host_int_ack && !host_reset_request) [*4];
  endsequence

  // ==========================================================
  // Board side assertions
  a_ack_needs_match: assert property ($rose(board_ack_to_host) |->
    $past(host_req, 3) && !$past(host_present_n, 3) &&
    ($past(board_addr_select, 3) == SLAVE_ADDR ||
     $past(broadcast_select, 3)))
    else $error("ack without addressed host request");
  a_ack_holds: assert property (board_ack_to_host && host_req |=>
    board_ack_to_host)
    else $error("ack dropped while request still up");
  a_ack_release: assert property (host_req_dropped |->
    ##[0:4] !board_ack_to_host)
    else $error("ack not released after request drop");
  a_breq_holds: assert property (
    board_to_host_req && !host_ack_to_board |=> board_to_host_req)
    else $error("board request dropped before host ack");
  a_breq_release: assert property (
    board_to_host_req && host_ack_to_board |-> ##[0:4] !board_to_host_req)
    else $error("board request not released after ack");
  a_data_before_req: assert property ($rose(board_to_host_req) |->
    $past(board_data_oe_n) == 1'b0 && !board_data_oe_n)
    else $error("board request without data driven first");
  a_bus_no_clash: assert property (
    board_data_oe_n || host_data_oe_n)
    else $error("both ends drive the data bus");
  a_irq_pull_low: assert property (!shared_host_irq_oe_n |->
    !shared_host_irq_o)
    else $error("shared interrupt driven high");
  a_irq_flag_line: assert property ($rose(irq_source_flag) |->
    ##[0:1] !shared_host_irq_n)
    else $error("source flag without shared interrupt pull");
  a_int_ack_clears: assert property (int_ack_held |=>
    !irq_source_flag && shared_host_irq_n)
    else $error("interrupt ack left flag or line active");
endmodule // hpl_link_sva

/* File: tb.sv */
// Self-checking bench joining both ends of the host parallel link
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [2:0] SLAVE = 3'h5; // Address given to the board
  // ==========================================================
  // Stimulus and observed signals
  logic       sys_clk = 1'b0;
  logic       reset   = 1'b1;
  logic [2:0] h_target, h_supply, b_powered;
  logic       h_bcast, h_break, h_reset, h_hard, h_int_ack;
  logic [7:0] h_tx_data, h_rx_data, b_tx_data, b_rx_data;
  logic       h_tx_valid, h_tx_ready, h_rx_valid, h_irq_pend, h_irq_src;
  logic       b_tx_valid, b_tx_ready, b_rx_valid, b_rx_ready, b_irq;
  logic       b_nmi, b_hard, b_soft, b_attached, b_gate_n;
  logic [7:0] host_q[$];                         // Words seen by host
  logic [7:0] hw[3] = '{8'ha5, 8'hff, 8'h00};    // Host to board words
  logic [7:0] bw[3] = '{8'h00, 8'hff, 8'h5a};    // Board to host words
  int         mismatches = 0;
  int         compares = 0;
  int         n, k;

  // ==========================================================
  // Both ends, the wires and the checker
  hpl_link_if lnk ();
  hpl_board #(.SLAVE_ADDR(SLAVE)) hpl_board_i (
    .sys_clk(sys_clk), .reset(reset), .link(lnk.board),
    .tx_data(b_tx_data), .tx_valid(b_tx_valid), .tx_ready(b_tx_ready),
    .rx_data(b_rx_data), .rx_valid(b_rx_valid), .rx_ready(b_rx_ready),
    .irq_raise(b_irq), .nmi_level7(b_nmi), .hard_reset_req(b_hard),
    .soft_reset_req(b_soft), .host_attached(b_attached),
    .host_powered(b_powered), .transceiver_gate_n(b_gate_n));
  hpl_host hpl_host_i (
    .sys_clk(sys_clk), .reset(reset), .link(lnk.host),
    .target_addr(h_target), .broadcast(h_bcast), .do_break(h_break),
    .do_reset(h_reset), .hard_kind(h_hard), .int_ack(h_int_ack),
    .supply_on(h_supply), .tx_data(h_tx_data), .tx_valid(h_tx_valid),
    .tx_ready(h_tx_ready), .rx_data(h_rx_data), .rx_valid(h_rx_valid),
    .irq_pending(h_irq_pend), .irq_source(h_irq_src));
  hpl_link_sva #(.SLAVE_ADDR(SLAVE)) hpl_link_sva_i (
    .sys_clk(sys_clk), .reset(reset),
    .board_addr_select(lnk.board_addr_select),
    .broadcast_select(lnk.broadcast_select),
    .host_present_n(lnk.host_present_n),
    .host_reset_request(lnk.host_reset_request),
    .host_req(lnk.host_req), .board_ack_to_host(lnk.board_ack_to_host),
    .board_to_host_req(lnk.board_to_host_req),
    .host_ack_to_board(lnk.host_ack_to_board),
    .host_int_ack(lnk.host_int_ack), .irq_source_flag(lnk.irq_source_flag),
    .shared_host_irq_o(lnk.shared_host_irq_o),
    .shared_host_irq_oe_n(lnk.shared_host_irq_oe_n),
    .shared_host_irq_n(lnk.shared_host_irq_n),
    .board_data_oe_n(lnk.board_data_oe_n),
    .host_data_oe_n(lnk.host_data_oe_n));

  // ==========================================================
  // Clock and host receive monitor
  always #25 sys_clk = ~sys_clk;
  // One entry per host receive pulse, sampled mid-cycle
  always @(negedge sys_clk) begin
    if (h_rx_valid === 1'b1) host_q.push_back(h_rx_data);
  end

  // ==========================================================
  // Comparison, verdict and hang handling
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results;
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic stall(input string what);
    mismatches++;
    $display("MISMATCH %s expected handshake seen timeout", what);
    results();
  endtask

  // ==========================================================
  // Stream access: offer a word, hold it until taken
  task automatic send(input bit to_host, input logic [7:0] d);
    @(negedge sys_clk);
    if (to_host) {b_tx_data, b_tx_valid} = {d, 1'b1};
    else {h_tx_data, h_tx_valid} = {d, 1'b1};
    #1;
    for (n = 0; n < 60 && (to_host ? b_tx_ready : h_tx_ready) !== 1'b1;
         n++) @(negedge sys_clk);
    if (n == 60) stall("stream send");
    @(negedge sys_clk);
    if (to_host) b_tx_valid = 1'b0;
    else h_tx_valid = 1'b0;
  endtask
  // Take one word from the board receive buffer
  task automatic recv(input logic [7:0] exp);
    for (n = 0; n < 60 && b_rx_valid !== 1'b1; n++) @(negedge sys_clk);
    if (n == 60) stall("board receive");
    chk("board rx_data", exp, b_rx_data);
    b_rx_ready = 1'b1;
    @(negedge sys_clk);
    b_rx_ready = 1'b0;
    @(negedge sys_clk);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {h_target, h_supply} = {SLAVE, 3'h5};
    {h_bcast, h_break, h_reset, h_hard, h_int_ack} = '0;
    {h_tx_data, h_tx_valid, b_tx_data, b_tx_valid} = '0;
    {b_rx_ready, b_irq} = '0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk("host_attached", 8'h01, {7'h0, b_attached});
    chk("host_powered", 8'h05, {5'h0, b_powered});
    chk("shared irq idle", 8'h01, {7'h0, lnk.shared_host_irq_n});
    chk("gate addressed", 8'h00, {7'h0, b_gate_n});
    // Third word meets a full buffer and waits unanswered
    foreach (hw[i]) send(0, hw[i]);
    repeat (20) @(negedge sys_clk);
    chk("ack when full", 8'h02, {6'h0, lnk.host_req,
        lnk.board_ack_to_host});
    foreach (hw[i]) recv(hw[i]);
    // Other address ignored until broadcast
    h_target = 3'h2;
    send(0, 8'h3c);
    repeat (20) @(negedge sys_clk);
    chk("ack unaddressed", 8'h00, {7'h0, lnk.board_ack_to_host});
    chk("gate unaddressed", 8'h01, {7'h0, b_gate_n});
    h_bcast = 1'b1;
    recv(8'h3c);
    repeat (10) @(negedge sys_clk);
    h_bcast = 1'b0;
    h_target = SLAVE;
    // Board to host, back to back
    foreach (bw[i]) send(1, bw[i]);
    for (n = 0; n < 60 && host_q.size() < 3; n++) @(negedge sys_clk);
    if (n == 60) stall("host receive");
    foreach (bw[i]) chk("host rx word", bw[i], host_q[i]);
    // Break: other address, broadcast, own address
    for (k = 0; k < 3; k++) begin
      h_target = (k == 2) ? SLAVE : 3'h2;
      h_bcast = (k == 1);
      h_break = 1'b1;
      repeat (6) @(negedge sys_clk);
      chk("nmi_level7", {7'h0, k != 0}, {7'h0, b_nmi});
    end
    h_break = 1'b0;
    // Reset: other address, hard, soft
    for (k = 0; k < 3; k++) begin
      h_target = (k == 0) ? 3'h2 : SLAVE;
      h_hard = (k < 2);
      h_reset = 1'b1;
      repeat (6) @(negedge sys_clk);
      chk("reset kind", {6'h0, k == 1, k == 2},
          {6'h0, b_hard, b_soft});
      h_reset = 1'b0;
      repeat (6) @(negedge sys_clk);
    end
    h_hard = 1'b0;
    // Interrupt raised, then acknowledged by the host
    b_irq = 1'b1;
    @(negedge sys_clk);
    b_irq = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk("irq raised", 8'h03, {6'h0, h_irq_pend, h_irq_src});
    h_int_ack = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk("irq acked", 8'h00, {6'h0, h_irq_pend, h_irq_src});
    chk("irq released", 8'h01, {7'h0, lnk.shared_host_irq_n});
    h_int_ack = 1'b0;
    repeat (4) @(negedge sys_clk);
    results();
  end
endmodule // tb
